/* File: rtl/write_protect_and_read_clear_cfg.sv */
`timescale 1ns/100ps
`default_nettype none
module write_protect_and_read_clear_cfg
    import protect_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    // SPI register access
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    input  wire logic                     i_rd_backdoor,
    input  wire logic [8:0]               i_addr,
    input  wire logic [15:0]              i_wdata,
    // Classification of current address by the address map
    input  wire logic                     i_addr_protectable,
    input  wire logic                     i_addr_ram_one_tail,
    input  wire logic                     i_addr_ram_two_tail,
    // Microcore write to a clear-on-read target this cycle
    input  wire logic [CLEAR_TARGETS-1:0] i_core_wr,
    // Register read data
    output logic [15:0]                   o_rdata,
    // Protection state
    output logic                          o_global_protect,
    output logic                          o_ram_one_tail_guard,
    output logic                          o_ram_two_tail_guard,
    // Write permit for the addressed register
    output logic                          o_wr_allow,
    // Clear strobes to target registers
    output logic [CLEAR_TARGETS-1:0]      o_clear_on_read,
    // Clear select bits
    output logic [SELECT_BITS-1:0]        o_clear_select
);

    logic [PROTECT_BITS-1:0] protect_r;
    logic [SELECT_BITS-1:0]  select_r;
    logic                    release_hit;
    logic                    wr_ok;
    logic [CLEAR_TARGETS-1:0] target_hit;

    assign release_hit = i_wr && (i_addr == ADDR_PROTECT_RELEASE)
                         && (i_wdata == RELEASE_PASSWORD);

    // Protect control: bits only set, cleared by release
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            protect_r <= PROTECT_RESET;
        end else if (release_hit) begin
            protect_r <= PROTECT_RESET;
        end else if (i_wr && (i_addr == ADDR_PROTECT_CONTROL)) begin
            protect_r <= protect_r | i_wdata[PROTECT_BITS-1:0];
        end
    end

    // Clear select, never protected
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            select_r <= SELECT_RESET;
        end else if (i_wr && (i_addr == ADDR_READ_CLEAR_SELECT)) begin
            select_r <= i_wdata[SELECT_BITS-1:0];
        end
    end

    // Write permit for addressed register
    always_comb begin
        wr_ok = 1'b1;
        if (i_addr_ram_one_tail) begin
            wr_ok = !protect_r[BIT_RAM_ONE_TAIL_GUARD];
        end else if (i_addr_ram_two_tail) begin
            wr_ok = !protect_r[BIT_RAM_TWO_TAIL_GUARD];
        end else if (i_addr_protectable) begin
            wr_ok = !protect_r[BIT_GLOBAL_PROTECT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wr_allow <= 1'b1;
        end else begin
            o_wr_allow <= wr_ok;
        end
    end

    // Target address decode
    always_comb begin
        target_hit = '0;
        target_hit[BIT_DIAG_C1_M0] = (i_addr[8:1] == ADDR_DIAG_C1_M0[8:1]);
        target_hit[BIT_DIAG_C1_M1] = (i_addr[8:1] == ADDR_DIAG_C1_M1[8:1]);
        target_hit[BIT_DIAG_C2_M0] = (i_addr[8:1] == ADDR_DIAG_C2_M0[8:1]);
        target_hit[BIT_DIAG_C2_M1] = (i_addr[8:1] == ADDR_DIAG_C2_M1[8:1]);
        target_hit[BIT_DRIVE_STATUS] = 1'b1;
        target_hit[BIT_CORE_C1_M0] = 1'b1;
        target_hit[BIT_CORE_C1_M1] = 1'b1;
        target_hit[BIT_CORE_C2_M0] = 1'b1;
        target_hit[BIT_CORE_C2_M1] = 1'b1;
    end

    // Clear strobes; core write in same cycle is kept for next read
    genvar g;
    generate
        for (g = 0; g < CLEAR_TARGETS; g = g + 1) begin : g_clr
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_clear_on_read[g] <= 1'b0;
                end else begin
                    o_clear_on_read[g] <= i_rd && !i_rd_backdoor
                                          && select_r[g] && target_hit[g]
                                          && !i_core_wr[g];
                end
            end
        end
    endgenerate

    // Read data and state outputs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd && (i_addr == ADDR_PROTECT_CONTROL)) begin
            o_rdata <= {13'h0000, protect_r};
        end else if (i_rd && (i_addr == ADDR_READ_CLEAR_SELECT)) begin
            o_rdata <= {7'h00, select_r};
        end else if (i_rd) begin
            o_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_global_protect     <= 1'b0;
            o_ram_one_tail_guard <= 1'b0;
            o_ram_two_tail_guard <= 1'b0;
            o_clear_select       <= SELECT_RESET;
        end else begin
            o_global_protect     <= protect_r[BIT_GLOBAL_PROTECT];
            o_ram_one_tail_guard <= protect_r[BIT_RAM_ONE_TAIL_GUARD];
            o_ram_two_tail_guard <= protect_r[BIT_RAM_TWO_TAIL_GUARD];
            o_clear_select       <= select_r;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/protect_cfg_pkg.sv */
package protect_cfg_pkg;
    // Register addresses
    localparam logic [8:0]  ADDR_PROTECT_CONTROL   = 9'h1cd;
    localparam logic [8:0]  ADDR_READ_CLEAR_SELECT = 9'h1ce;
    localparam logic [8:0]  ADDR_PROTECT_RELEASE   = 9'h1cf;
    // Release password
    localparam logic [15:0] RELEASE_PASSWORD       = 16'h1337;
    // Protect control field positions
    localparam int          BIT_GLOBAL_PROTECT     = 0;
    localparam int          BIT_RAM_ONE_TAIL_GUARD = 1;
    localparam int          BIT_RAM_TWO_TAIL_GUARD = 2;
    localparam int          PROTECT_BITS           = 3;
    // Read clear select field positions
    localparam int          BIT_DRIVE_STATUS       = 0;
    localparam int          BIT_DIAG_C1_M0         = 1;
    localparam int          BIT_DIAG_C1_M1         = 2;
    localparam int          BIT_DIAG_C2_M0         = 3;
    localparam int          BIT_DIAG_C2_M1         = 4;
    localparam int          BIT_CORE_C1_M0         = 5;
    localparam int          BIT_CORE_C1_M1         = 6;
    localparam int          BIT_CORE_C2_M0         = 7;
    localparam int          BIT_CORE_C2_M1         = 8;
    localparam int          SELECT_BITS            = 9;
    // Reset values
    localparam logic [PROTECT_BITS-1:0] PROTECT_RESET = 3'h0;
    localparam logic [SELECT_BITS-1:0]  SELECT_RESET  = 9'h000;
    // Cleared register targets: drive status, four diag pairs, four core status
    localparam int          CLEAR_TARGETS          = 9;
    // Diagnosis error pair addresses (low word of each pair)
    localparam logic [8:0]  ADDR_DIAG_C1_M0        = 9'h162;
    localparam logic [8:0]  ADDR_DIAG_C1_M1        = 9'h164;
    localparam logic [8:0]  ADDR_DIAG_C2_M0        = 9'h166;
    localparam logic [8:0]  ADDR_DIAG_C2_M1        = 9'h168;
endpackage

/* File: bench/protect_cfg_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module protect_cfg_checker
    import protect_cfg_pkg::*;
(
    // Watched ports
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_rd_backdoor,
    input wire logic [8:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [8:0]  i_core_wr,
    input wire logic        o_global_protect,
    input wire logic [8:0]  o_clear_on_read,
    input wire logic [8:0]  o_clear_select
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic pw;
    assign pw = i_wr && i_addr == ADDR_PROTECT_RELEASE && i_wdata == RELEASE_PASSWORD;
    lock_set_a: assert property (i_wr && i_addr == ADDR_PROTECT_CONTROL && i_wdata[0]
        |-> ##2 o_global_protect) else $error("lock not set");
    lock_hold_a: assert property ($fell(o_global_protect)
        |-> $past(pw, 2) || $past(i_rst, 2) || $past(i_rst)) else $error("lock dropped");
    release_a: assert property (pw |-> ##2 !o_global_protect) else $error("no release");
    backdoor_a: assert property (i_rd && i_rd_backdoor |=> o_clear_on_read == '0)
        else $error("backdoor cleared");
    idle_clear_a: assert property (!i_rd |=> o_clear_on_read == '0) else $error("stray clear");
    diag_clear_a: assert property (i_rd && !i_rd_backdoor && o_clear_select[2]
        && !i_core_wr[2] && !$past(i_wr && i_addr == ADDR_READ_CLEAR_SELECT)
        && i_addr[8:1] == ADDR_DIAG_C1_M1[8:1] |=> o_clear_on_read[2]) else $error("no clear");
    core_hold_a: assert property (i_rd && i_core_wr[1] |=> !o_clear_on_read[1])
        else $error("write lost");
    select_write_a: assert property ($rose(o_clear_select[8]) |-> $past(i_wr, 2)
        && $past(i_addr, 2) == ADDR_READ_CLEAR_SELECT) else $error("select moved");
endmodule
bind write_protect_and_read_clear_cfg protect_cfg_checker protect_cfg_checker_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_rd_backdoor(i_rd_backdoor),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_core_wr(i_core_wr),
    .o_global_protect(o_global_protect), .o_clear_on_read(o_clear_on_read),
    .o_clear_select(o_clear_select));
`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic   i_clk,
    // Register request
    output logic        o_wr,
    output logic        o_rd,
    output logic        o_bd,
    output logic [8:0]  o_addr,
    output logic [15:0] o_wdata
);
    initial {o_wr, o_rd, o_bd, o_addr, o_wdata} = '0;
    // One access held up to its taking edge
    task automatic go(input logic w, r, b, input logic [8:0] a, input logic [15:0] d);
        @(posedge i_clk) #1 {o_wr, o_rd, o_bd, o_addr, o_wdata} = {w, r, b, a, d};
        @(posedge i_clk) #1 {o_wr, o_rd, o_bd} = '0;
        o_wdata = ~d;
    endtask
endmodule
`default_nettype wire

/* File: bench/write_protect_and_read_clear_cfg_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module write_protect_and_read_clear_cfg_bench;
    import protect_cfg_pkg::*;
    logic i_clk = 0, i_rst = 1, wr_s, rd_s, bd, prot = 0, t1 = 0, t2 = 0, gp, g1, g2, ok;
    logic [8:0]  addr, clr, sel, core_wr = '0;
    logic [15:0] wdata, rdata;
    int          num_errors = 0, samples_checked = 0;
    initial forever #25 i_clk = ~i_clk;
    host_model host_model_inst (.i_clk(i_clk), .o_wr(wr_s), .o_rd(rd_s), .o_bd(bd),
        .o_addr(addr), .o_wdata(wdata));
    write_protect_and_read_clear_cfg write_protect_and_read_clear_cfg_inst (.i_clk(i_clk),
        .i_rst(i_rst), .i_wr(wr_s), .i_rd(rd_s), .i_rd_backdoor(bd), .i_addr(addr),
        .i_wdata(wdata), .i_addr_protectable(prot), .i_addr_ram_one_tail(t1),
        .i_addr_ram_two_tail(t2), .i_core_wr(core_wr), .o_rdata(rdata),
        .o_global_protect(gp), .o_ram_one_tail_guard(g1), .o_ram_two_tail_guard(g2),
        .o_wr_allow(ok), .o_clear_on_read(clr), .o_clear_select(sel));
    task automatic chk(input string n, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic rd(input logic [8:0] a, input logic b = 0);
        host_model_inst.go(0, 1, b, a, 0);
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        host_model_inst.go(1, 0, 0, a, d);
    endtask
    initial begin
        #20000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_rst = 0;
        rd(ADDR_READ_CLEAR_SELECT);
        chk("select", rdata, 16'h0);
        rd(ADDR_DIAG_C1_M0);
        chk("clear", 16'(clr), 16'h0);
        wr(ADDR_READ_CLEAR_SELECT, 16'h01ff);
        rd(ADDR_READ_CLEAR_SELECT);
        chk("select", rdata, 16'h01ff);
        chk("select_out", 16'(sel), 16'h01ff);
        for (int k = 0; k < 4; k++) begin
            rd(ADDR_DIAG_C1_M0 + 9'(2 * k + 1));
            chk("clear", 16'(clr), 16'h1e1 | 16'(2 << k));
        end
        rd(ADDR_DIAG_C1_M0, 1);
        chk("backdoor", 16'(clr), 16'h0);
        core_wr = 9'h002;
        rd(ADDR_DIAG_C1_M0);
        chk("clear", 16'(clr[1]), 16'h0);
        core_wr = '0;
        rd(ADDR_DIAG_C1_M0);
        chk("clear", 16'(clr[1]), 16'h1);
        prot = 1;
        wr(ADDR_PROTECT_CONTROL, 16'h0001);
        wr(9'h010, 16'h1234);
        chk("allow", 16'(ok), 16'h0);
        {prot, t1, t2} = 3'b110;
        wr(9'h1f0, 16'h1234);
        chk("allow", 16'(ok), 16'h1);
        {t1, t2} = 2'b00;
        wr(ADDR_PROTECT_CONTROL, 16'h0006);
        {t1, t2} = 2'b11;
        wr(9'h1f0, 16'h1234);
        chk("allow", 16'(ok), 16'h0);
        {t1, t2} = 2'b01;
        wr(9'h1f0, 16'h1234);
        chk("allow", 16'(ok), 16'h0);
        {t1, t2} = 2'b00;
        wr(ADDR_PROTECT_CONTROL, 16'h0000);
        wr(ADDR_PROTECT_RELEASE, 16'h1338);
        rd(ADDR_PROTECT_CONTROL);
        chk("lock", rdata, 16'h0007);
        chk("guards", 16'({g2, g1, gp}), 16'h0007);
        wr(ADDR_PROTECT_RELEASE, RELEASE_PASSWORD);
        rd(ADDR_PROTECT_CONTROL);
        chk("lock", rdata, 16'h0);
        chk("guards", 16'({g2, g1, gp}), 16'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
